// ===== rtl/pb_pkg.sv
// Shared constants and carrier types for the pushbutton wiper controller.
package pb_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int SERIAL_READY_NS = 10000;
    localparam int SERIAL_READY_CYCLES =
        (SERIAL_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MS_NS = 1000000;
    localparam int MS_TICK_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
    localparam int POWERUP_MS = 50;
    localparam int MIN_PULSE_MS = 1;
    localparam int HOLD_MS = 1000;
    localparam int REPEAT_MS = 100;
    localparam int GAP_MS = 1;
    localparam int IDLE_MS = 1000;
    localparam int MS_CNT_W = 11;
    localparam int SER_CNT_W = 8;
    localparam int PWR_CNT_W = 6;

    // ------------------------------------------------------------------
    // Wiper positions
    // ------------------------------------------------------------------
    localparam int POS_W = 7;
    localparam logic [6:0] POS_HIGH_END = 7'h00;
    localparam logic [6:0] POS_LOW_END = 7'h3f;
    localparam logic [6:0] POS_MUTE = 7'h40;
    localparam logic [6:0] POS_RESET = 7'h3f;

    // ------------------------------------------------------------------
    // Pushbutton terminals
    // ------------------------------------------------------------------
    localparam int PIN_COUNT = 4;
    localparam int PIN_A = 0;
    localparam int PIN_B = 1;
    localparam int PIN_C = 2;
    localparam int PIN_D = 3;

    typedef logic [POS_W-1:0] pos_t;

    typedef struct packed {
        pos_t pos1;
        pos_t pos0;
    } wiper_pair_t;

    typedef struct packed {
        logic mute;
        logic [5:0] db;
    } atten_t;

    typedef enum logic {ST_POWERUP, ST_ACTIVE} run_state_t;

endpackage : pb_pkg

// ===== rtl/button_timer.sv
// Synchroniser, debounce and press timing for one pushbutton terminal.
`timescale 1ns/1ps
module button_timer
    import pb_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic msTick,
    input wire logic enable,
    input wire logic pinRaw,
    output logic stepPulse,
    output logic revPulse
);

    logic syncA;
    logic syncB;
    logic pressed;
    logic [MS_CNT_W-1:0] lowMs;
    logic [MS_CNT_W-1:0] highMs;
    logic [MS_CNT_W-1:0] idleMs;
    logic idleLong;

    // ------------------------------------------------------------------
    // Input synchroniser
    // ------------------------------------------------------------------
    // The idle level of a pulled-up terminal is high, so reset to high.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            syncA <= 1'b1;
            syncB <= 1'b1;
        end else begin
            syncA <= pinRaw;
            syncB <= syncA;
        end
    end

    assign idleLong = (idleMs >= MS_CNT_W'(IDLE_MS));

    // ------------------------------------------------------------------
    // Press timing
    // ------------------------------------------------------------------
    // Timing is quantised to the 1 ms tick, so widths are known to +-1 ms.
    always_ff @(posedge mclk) begin
        stepPulse <= 1'b0;
        revPulse <= 1'b0;
        if (!rst_n || !enable) begin
            lowMs <= '0;
            highMs <= '0;
            idleMs <= MS_CNT_W'(IDLE_MS);
            pressed <= 1'b0;
        end else if (msTick) begin
            if (!syncB) begin
                highMs <= '0;
                lowMs <= lowMs + 1'b1;
                if (!pressed && lowMs == MS_CNT_W'(MIN_PULSE_MS)) begin
                    pressed <= 1'b1;
                    stepPulse <= 1'b1;
                    revPulse <= idleLong;
                end else if (pressed &&
                             lowMs == MS_CNT_W'(HOLD_MS + REPEAT_MS - 1)) begin
                    stepPulse <= 1'b1;
                    lowMs <= MS_CNT_W'(HOLD_MS);
                end
            end else if (pressed) begin
                // A release shorter than the gap is part of the same press.
                if (highMs >= MS_CNT_W'(GAP_MS)) begin
                    pressed <= 1'b0;
                    lowMs <= '0;
                    highMs <= '0;
                    idleMs <= '0;
                end else begin
                    highMs <= highMs + 1'b1;
                end
            end else begin
                lowMs <= '0;
                if (!idleLong) begin
                    idleMs <= idleMs + 1'b1;
                end
            end
        end
    end

endmodule : button_timer

// ===== rtl/pushbutton_wiper_control.sv
// Pushbutton control of two 65-position logarithmic attenuator wipers.
//
// Overview of operation
// - Serial load port ready within 10 us.
// - Ignore pushbuttons until 50 ms after power-up.
// - Both wipers start at position 63.
// - Positions 0..63 give n dB attenuation.
// - Position 64 decodes as mute.
// - Four terminals plus mode give eight functions.
// - Mode sampled once at power-up and held.
// - Mode high independent, low stereo.
// - Up moves toward high end, down toward low.
// - Each independent pair drives only its wiper.
// - Single-button: up inputs move both directions.
// - Stereo: volume up, down, balance 0, 1.
// - Volume steps both wipers, keeping their difference.
// - Volume stops when either wiper hits an end.
// - First balance captures the nearer-high wiper position.
// - Balance 0 raises wiper 0 until equal.
// - Then balance 0 attenuates wiper 1 further.
// - Wiper 1 at bottom: balance 0 does nothing.
// - Both at 63: balance never moves them.
// - Press over 1 ms moves one step.
// - Held over 1 s repeats every 100 ms.
// - Single-button reverses after 1 s idle.
`timescale 1ns/1ps
module pushbutton_wiper_control
    import pb_pkg::*;
#(
    parameter int MS_TICK_CYCLES = MS_TICK_CYCLES_DEF
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic modeSelPin,
    input wire logic singleButtonPin,
    input wire logic [PIN_COUNT-1:0] pushPin,
    input wire logic posLoadValid,
    input wire wiper_pair_t posLoad,
    output wiper_pair_t wiperPos,
    output atten_t atten0,
    output atten_t atten1,
    output logic serialReady,
    output logic buttonsActive,
    output logic independentMode,
    output logic singleButton
);

    // ------------------------------------------------------------------
    // Elaboration checks and helper functions
    // ------------------------------------------------------------------
    if (MS_TICK_CYCLES < 2) begin : g_bad_tick
        $error("MS_TICK_CYCLES must be at least 2");
    end

    // Toward the high end; a muted wiper comes back to the low end first.
    function automatic pos_t posUp(input pos_t p);
        if (p == POS_HIGH_END) begin
            return p;
        end
        return p - 1'b1;
    endfunction : posUp

    function automatic pos_t posDown(input pos_t p);
        if (p >= POS_LOW_END) begin
            return p;
        end
        return p + 1'b1;
    endfunction : posDown

    function automatic pos_t posMove(input pos_t p, input logic up);
        return up ? posUp(p) : posDown(p);
    endfunction : posMove

    // Single-button direction: a long idle reverses it, and so does an end stop.
    function automatic logic nextDir(input logic dir, input logic rev,
                                     input logic stuckUp, input logic stuckDown);
        logic d;
        d = dir ^ rev;
        if (d ? stuckUp : stuckDown) begin
            d = ~d;
        end
        return d;
    endfunction : nextDir

    function automatic wiper_pair_t volStep(input wiper_pair_t w,
                                            input logic up);
        wiper_pair_t r;
        r = w;
        if (up && w.pos0 != POS_HIGH_END && w.pos1 != POS_HIGH_END) begin
            r.pos0 = posUp(w.pos0);
            r.pos1 = posUp(w.pos1);
        end else if (!up && w.pos0 < POS_LOW_END && w.pos1 < POS_LOW_END) begin
            r.pos0 = posDown(w.pos0);
            r.pos1 = posDown(w.pos1);
        end
        return r;
    endfunction : volStep

    // Side 0 pulls wiper 0 toward the held reference, side 1 mirrors it.
    function automatic wiper_pair_t balStep(input wiper_pair_t w,
                                            input pos_t refPos,
                                            input logic side1);
        pos_t own;
        pos_t other;
        own = side1 ? w.pos1 : w.pos0;
        other = side1 ? w.pos0 : w.pos1;
        if (own > refPos) begin
            own = posUp(own);
        end else if (other < POS_LOW_END) begin
            other = posDown(other);
        end
        // Other wiper at the bottom: nothing moves, which also covers 63/63.
        return side1 ? {own, other} : {other, own};
    endfunction : balStep

    function automatic atten_t decodeAtten(input pos_t p);
        atten_t a;
        a.mute = (p >= POS_MUTE);
        a.db = a.mute ? 6'h3f : p[5:0];
        return a;
    endfunction : decodeAtten

    // ------------------------------------------------------------------
    // Millisecond tick divider
    // ------------------------------------------------------------------
    logic [31:0] tickCnt_reg;
    logic msTick_reg;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tickCnt_reg <= 32'h0;
            msTick_reg <= 1'b0;
        end else if (tickCnt_reg == 32'(MS_TICK_CYCLES - 1)) begin
            tickCnt_reg <= 32'h0;
            msTick_reg <= 1'b1;
        end else begin
            tickCnt_reg <= tickCnt_reg + 32'h1;
            msTick_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Strap synchronisers and power-up sequencing
    // ------------------------------------------------------------------
    logic modeSyncA;
    logic modeSyncB;
    logic singleSyncA;
    logic singleSyncB;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            modeSyncA <= 1'b0;
            modeSyncB <= 1'b0;
            singleSyncA <= 1'b0;
            singleSyncB <= 1'b0;
        end else begin
            modeSyncA <= modeSelPin;
            modeSyncB <= modeSyncA;
            singleSyncA <= singleButtonPin;
            singleSyncB <= singleSyncA;
        end
    end

    run_state_t state_reg;
    logic [SER_CNT_W-1:0] serCnt_reg;
    logic [PWR_CNT_W-1:0] pwrMs_reg;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            serCnt_reg <= '0;
            serialReady <= 1'b0;
        end else if (serCnt_reg == SER_CNT_W'(SERIAL_READY_CYCLES - 1)) begin
            serialReady <= 1'b1;
        end else begin
            serCnt_reg <= serCnt_reg + 1'b1;
        end
    end

    // The straps are caught on the clock, after reset has released.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_reg <= ST_POWERUP;
            pwrMs_reg <= '0;
            buttonsActive <= 1'b0;
            independentMode <= 1'b0;
            singleButton <= 1'b0;
        end else begin
            case (state_reg)
                ST_POWERUP: begin
                    if (msTick_reg) begin
                        pwrMs_reg <= pwrMs_reg + 1'b1;
                    end
                    if (pwrMs_reg == PWR_CNT_W'(POWERUP_MS)) begin
                        state_reg <= ST_ACTIVE;
                        buttonsActive <= 1'b1;
                        independentMode <= modeSyncB;
                        singleButton <= singleSyncB;
                    end
                end
                ST_ACTIVE: begin
                    buttonsActive <= 1'b1;
                end
                default: begin
                    state_reg <= ST_POWERUP;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Pushbutton terminals and wiper state
    // ------------------------------------------------------------------
    logic [PIN_COUNT-1:0] stepPulse;
    logic [PIN_COUNT-1:0] revPulse;

    for (genvar g = 0; g < PIN_COUNT; g++) begin : g_pin
        button_timer u_timer (
            .mclk(mclk),
            .rst_n(rst_n),
            .msTick(msTick_reg),
            .enable(buttonsActive),
            .pinRaw(pushPin[g]),
            .stepPulse(stepPulse[g]),
            .revPulse(revPulse[g])
        );
    end

    wiper_pair_t wiper_reg;
    wiper_pair_t wiper_next;
    pos_t balRef_reg;
    pos_t balRef_next;
    logic balRefValid_reg;
    logic balRefValid_next;
    logic [2:0] dirUp_reg;
    logic [2:0] dirUp_next;
    logic balSide_reg;
    logic balSide_next;

    // Simultaneous presses land on the same tick, so all are applied in turn.
    always_comb begin
        wiper_next = wiper_reg;
        balRef_next = balRef_reg;
        balRefValid_next = balRefValid_reg;
        dirUp_next = dirUp_reg;
        balSide_next = balSide_reg;
        if (posLoadValid && serialReady) begin
            wiper_next = posLoad;
            balRefValid_next = 1'b0;
        end else if (buttonsActive) begin
            for (int i = 0; i < PIN_COUNT; i++) begin
                if (stepPulse[i] && independentMode) begin
                    case (i)
                        PIN_A: begin
                            if (!singleButton) begin
                                wiper_next.pos0 = posUp(wiper_next.pos0);
                            end else begin
                                dirUp_next[0] = nextDir(dirUp_next[0], revPulse[i],
                                    posUp(wiper_next.pos0) == wiper_next.pos0,
                                    posDown(wiper_next.pos0) == wiper_next.pos0);
                                wiper_next.pos0 = posMove(wiper_next.pos0, dirUp_next[0]);
                            end
                        end
                        PIN_B: begin
                            if (!singleButton) begin
                                wiper_next.pos1 = posUp(wiper_next.pos1);
                            end else begin
                                dirUp_next[1] = nextDir(dirUp_next[1], revPulse[i],
                                    posUp(wiper_next.pos1) == wiper_next.pos1,
                                    posDown(wiper_next.pos1) == wiper_next.pos1);
                                wiper_next.pos1 = posMove(wiper_next.pos1, dirUp_next[1]);
                            end
                        end
                        PIN_C: begin
                            if (!singleButton) begin
                                wiper_next.pos0 = posDown(wiper_next.pos0);
                            end
                        end
                        PIN_D: begin
                            if (!singleButton) begin
                                wiper_next.pos1 = posDown(wiper_next.pos1);
                            end
                        end
                        default: begin
                        end
                    endcase
                end else if (stepPulse[i]) begin
                    case (i)
                        PIN_A: begin
                            balRefValid_next = 1'b0;
                            if (!singleButton) begin
                                wiper_next = volStep(wiper_next, 1'b1);
                            end else begin
                                dirUp_next[2] = nextDir(dirUp_next[2], revPulse[i],
                                    volStep(wiper_next, 1'b1) == wiper_next,
                                    volStep(wiper_next, 1'b0) == wiper_next);
                                wiper_next = volStep(wiper_next, dirUp_next[2]);
                            end
                        end
                        PIN_C: begin
                            if (!singleButton) begin
                                balRefValid_next = 1'b0;
                                wiper_next = volStep(wiper_next, 1'b0);
                            end
                        end
                        PIN_B, PIN_D: begin
                            if (!(singleButton && i == PIN_D)) begin
                                if (!balRefValid_next) begin
                                    balRefValid_next = 1'b1;
                                    balRef_next = (wiper_next.pos0 < wiper_next.pos1)
                                                  ? wiper_next.pos0 : wiper_next.pos1;
                                end
                                if (singleButton && revPulse[i]) begin
                                    balSide_next = ~balSide_next;
                                end
                                wiper_next = balStep(wiper_next, balRef_next,
                                                     singleButton ? balSide_next
                                                                  : (i == PIN_D));
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wiper_reg <= '{pos1: POS_RESET, pos0: POS_RESET};
            balRef_reg <= POS_RESET;
            balRefValid_reg <= 1'b0;
            dirUp_reg <= 3'h0;
            balSide_reg <= 1'b1;
        end else begin
            wiper_reg <= wiper_next;
            balRef_reg <= balRef_next;
            balRefValid_reg <= balRefValid_next;
            dirUp_reg <= dirUp_next;
            balSide_reg <= balSide_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Attenuation follows the wiper one cycle later so that it is registered.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wiperPos <= '{pos1: POS_RESET, pos0: POS_RESET};
            atten0 <= decodeAtten(POS_RESET);
            atten1 <= decodeAtten(POS_RESET);
        end else begin
            wiperPos <= wiper_next;
            atten0 <= decodeAtten(wiper_reg.pos0);
            atten1 <= decodeAtten(wiper_reg.pos1);
        end
    end

endmodule : pushbutton_wiper_control

// ===== tb/button_bank.sv
// Model of the pushbuttons that close each pin to ground.
`timescale 1ns/1ps
module button_bank (
    input wire logic [3:0] pressed,
    output logic [3:0] pushPin
);
    // An open contact is held high by the pull-up, so no pin ever floats.
    assign pushPin = ~pressed;
endmodule : button_bank

// ===== tb/pwc_chk.sv
// Port checker for the pushbutton wiper controller.
`timescale 1ns/1ps
module pwc_chk
    import pb_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic posLoadValid,
    input wire wiper_pair_t posLoad,
    input wire wiper_pair_t wiperPos,
    input wire atten_t atten0,
    input wire atten_t atten1,
    input wire logic serialReady,
    input wire logic buttonsActive,
    input wire logic independentMode
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    chk_load_taken: assert property (
        posLoadValid && serialReady |=> wiperPos == $past(posLoad))
        else $error("load not taken");
    chk_ready_time: assert property ($rose(rst_n) |-> ##[1:251] serialReady)
        else $error("serial port late");
    chk_buttons_idle: assert property (
        !buttonsActive && !(posLoadValid && serialReady) |=> $stable(wiperPos))
        else $error("wiper moved while buttons idle");
    chk_active_order: assert property (buttonsActive |-> serialReady)
        else $error("buttons active before serial port");
    chk_db_map: assert property (
        wiperPos.pos0 < POS_MUTE |=> atten0 == {1'b0, $past(wiperPos.pos0[5:0])})
        else $error("attenuation map wrong");
    chk_mute_map: assert property (
        wiperPos.pos1 == POS_MUTE |=> atten1.mute && atten1.db == 6'h3f)
        else $error("mute not decoded");
    chk_mode_frozen: assert property (
        buttonsActive ##1 buttonsActive |-> $stable(independentMode))
        else $error("mode changed after latch");
    chk_one_step: assert property (
        independentMode && !posLoadValid |=> wiperPos.pos0 == $past(wiperPos.pos0)
        || wiperPos.pos0 == $past(wiperPos.pos0) + 7'h01
        || wiperPos.pos0 == $past(wiperPos.pos0) - 7'h01)
        else $error("wiper moved more than one step");
    chk_no_wrap: assert property (
        !posLoadValid && wiperPos.pos0 <= POS_LOW_END |=> wiperPos.pos0 <= POS_LOW_END)
        else $error("wiper left stepping range");

    cover property (posLoadValid && serialReady);
    cover property ($rose(buttonsActive));
    cover property (atten1.mute);
endmodule : pwc_chk

bind pushbutton_wiper_control pwc_chk chk (
    .mclk(mclk),
    .rst_n(rst_n),
    .posLoadValid(posLoadValid),
    .posLoad(posLoad),
    .wiperPos(wiperPos),
    .atten0(atten0),
    .atten1(atten1),
    .serialReady(serialReady),
    .buttonsActive(buttonsActive),
    .independentMode(independentMode)
);

// ===== tb/tb_top.sv
// Self-checking bench for the pushbutton wiper controller.
`timescale 1ns/1ps
module tb_top;
    import pb_pkg::*;
    // Short tick keeps the 1 s hold case to about 11500 cycles.
    localparam int TICK = 10;
    typedef struct packed {logic m; pos_t l0; pos_t l1; logic [1:0] pin;
        pos_t e0; pos_t e1;} row_t;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic modeSelPin = 1'b1;
    logic singleButtonPin = 1'b0;
    logic posLoadValid = 1'b0;
    wiper_pair_t posLoad = '0;
    logic [3:0] pressed = 4'h0;
    logic [3:0] pushPin;
    wiper_pair_t wiperPos;
    atten_t atten0;
    atten_t atten1;
    logic serialReady;
    logic buttonsActive;
    logic independentMode;
    logic singleButton;
    int num_errors = 0;
    int n_checks = 0;
    row_t rows [14] = '{
        '{1'b1, 7'h1e, 7'h28, 2'h0, 7'h1d, 7'h28}, '{1'b1, 7'h1e, 7'h28, 2'h2, 7'h1f, 7'h28},
        '{1'b1, 7'h1e, 7'h28, 2'h1, 7'h1e, 7'h27}, '{1'b1, 7'h1e, 7'h28, 2'h3, 7'h1e, 7'h29},
        '{1'b1, 7'h00, 7'h3f, 2'h0, 7'h00, 7'h3f}, '{1'b1, 7'h00, 7'h3f, 2'h3, 7'h00, 7'h3f},
        '{1'b0, 7'h1c, 7'h14, 2'h0, 7'h1b, 7'h13}, '{1'b0, 7'h1c, 7'h14, 2'h2, 7'h1d, 7'h15},
        '{1'b0, 7'h00, 7'h05, 2'h0, 7'h00, 7'h05}, '{1'b0, 7'h1c, 7'h14, 2'h1, 7'h1b, 7'h14},
        '{1'b0, 7'h14, 7'h14, 2'h1, 7'h14, 7'h15}, '{1'b0, 7'h14, 7'h3f, 2'h1, 7'h14, 7'h3f},
        '{1'b0, 7'h3f, 7'h3f, 2'h1, 7'h3f, 7'h3f}, '{1'b0, 7'h14, 7'h1c, 2'h3, 7'h14, 7'h1b}
    };

    button_bank pb (.pressed(pressed), .pushPin(pushPin));
    pushbutton_wiper_control #(.MS_TICK_CYCLES(TICK)) dut (.mclk(mclk), .rst_n(rst_n),
        .modeSelPin(modeSelPin), .singleButtonPin(singleButtonPin), .pushPin(pushPin),
        .posLoadValid(posLoadValid), .posLoad(posLoad), .wiperPos(wiperPos),
        .atten0(atten0), .atten1(atten1), .serialReady(serialReady),
        .buttonsActive(buttonsActive), .independentMode(independentMode),
        .singleButton(singleButton));

    initial begin
        forever #20 mclk = ~mclk;
    end

    // ------------------------------------------------------------------
    // Stimulus and compare tasks
    // ------------------------------------------------------------------
    task automatic chkVal(input logic [13:0] got, input logic [13:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chkVal

    task automatic wrap_up;
        if (num_errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up

    // A button is held through reset and released 400 cycles into start-up; it must leave no trace.
    task automatic restart(input logic mode);
        int n;
        @(negedge mclk);
        rst_n = 1'b0;
        modeSelPin = mode;
        pressed = 4'h1;
        repeat (5) @(negedge mclk);
        chkVal(wiperPos, {POS_RESET, POS_RESET});
        chkVal({atten1, atten0}, {1'b0, POS_RESET[5:0], 1'b0, POS_RESET[5:0]});
        rst_n = 1'b1;
        posLoadValid = 1'b1;
        n = 0;
        while (buttonsActive !== 1'b1 && n < 2000) begin
            @(negedge mclk);
            posLoadValid = 1'b0;
            n++;
            if (n == 400) begin
                pressed = 4'h0;
            end
        end
        if (n == 2000) begin
            num_errors++;
            wrap_up();
        end
        chkVal(14'(n >= POWERUP_MS * TICK), 14'h0001);
        chkVal(wiperPos, {POS_RESET, POS_RESET});
        chkVal(14'(independentMode), 14'(mode));
        chkVal(14'(singleButton), 14'(singleButtonPin));
    endtask : restart

    task automatic load(input pos_t p0, input pos_t p1);
        posLoad = {p1, p0};
        posLoadValid = 1'b1;
        @(negedge mclk);
        posLoadValid = 1'b0;
        @(negedge mclk);
    endtask : load

    task automatic press(input int pin, input int ms);
        pressed[pin] = 1'b1;
        repeat (ms * TICK) @(negedge mclk);
        pressed[pin] = 1'b0;
        repeat (5 * TICK) @(negedge mclk);
    endtask : press

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        restart(1'b1);
        foreach (rows[i]) begin
            if (rows[i].m !== modeSelPin) begin
                restart(rows[i].m);
            end
            load(rows[i].l0, rows[i].l1);
            press(rows[i].pin, 5);
            chkVal(wiperPos, {rows[i].e1, rows[i].e0});
            chkVal({atten1, atten0}, {1'b0, rows[i].e1[5:0], 1'b0, rows[i].e0[5:0]});
        end
        load(POS_MUTE, POS_MUTE);
        chkVal({atten1, atten0}, 14'h3fff);
        restart(1'b1);
        load(7'h1e, 7'h28);
        press(0, 1150);
        chkVal(wiperPos, {7'h28, 7'h1c});
        // Single-button straps: the first press after start-up counts as a long idle.
        singleButtonPin = 1'b1;
        restart(1'b0);
        load(7'h1e, 7'h28);
        press(0, 5);
        chkVal(wiperPos, {7'h27, 7'h1d});
        press(1, 5);
        press(3, 5);
        chkVal(wiperPos, {7'h28, 7'h1d});
        restart(1'b1);
        load(7'h1e, 7'h28);
        press(0, 5);
        press(0, 5);
        chkVal(wiperPos, {7'h28, 7'h1c});
        repeat (IDLE_MS * TICK + 100) @(negedge mclk);
        press(0, 5);
        chkVal(wiperPos, {7'h28, 7'h1d});
        press(2, 5);
        chkVal(wiperPos, {7'h28, 7'h1d});
        load(POS_LOW_END, 7'h28);
        press(0, 5);
        chkVal(wiperPos, {7'h28, 7'h3e});
        wrap_up();
    end
endmodule : tb_top
